/* File: logic/fql_regs.svh */
`ifndef FQL_REGS_SVH
`define FQL_REGS_SVH
// opcodes handled inside the command interpreter
`define FQL_OP_QUAD_ENTER 8'h35
`define FQL_OP_QUAD_EXIT 8'hf5
`define FQL_OP_PAUSE_A 8'h75
`define FQL_OP_PAUSE_B 8'hb0
`define FQL_OP_CONT_A 8'h7a
`define FQL_OP_CONT_B 8'h30
`define FQL_OP_SLEEP 8'hb9
`define FQL_OP_WAKE 8'hab
`define FQL_OP_WRITE_LATCH_SET_CMD 8'h06
`define FQL_OP_WRDI 8'h04
`define FQL_OP_RST_ARM 8'h66
`define FQL_OP_RST 8'h99
`define FQL_OP_STAT_RD 8'h05
`define FQL_OP_FUNC_RD 8'h48
`define FQL_OP_PP 8'h02
`define FQL_OP_PPQ_A 8'h32
`define FQL_OP_PPQ_B 8'h38
`define FQL_OP_LOCK 8'h24
`define FQL_OP_UNLOCK 8'h26
// bits in one opcode, bits per quad nibble
`define FQL_OP_BITS 4'd8
`define FQL_NIB_BITS 4'd4
// status byte and function byte fields
`define FQL_SR_BUSY 0
`define FQL_SR_WLATCH 1
`define FQL_FR_PPAUSE 2
`define FQL_FR_EPAUSE 3
// timing
`define FQL_CLK_MHZ 200
`define FQL_T_SUS_US 100
`define FQL_T_RS_US 80
`define FQL_T_DP_NS 3000
`define FQL_T_RES_NS 5000
`define FQL_SUS_CYC (`FQL_T_SUS_US * `FQL_CLK_MHZ)
`define FQL_RS_CYC (`FQL_T_RS_US * `FQL_CLK_MHZ)
`define FQL_DP_CYC ((`FQL_T_DP_NS * `FQL_CLK_MHZ) / 1000)
`define FQL_RES_CYC ((`FQL_T_RES_NS * `FQL_CLK_MHZ + 999) / 1000)
`define FQL_SCK_HALF 8
// host register word indexes (byte address is four times the index)
`define FQL_HR_CMD 2'd0
`define FQL_HR_STAT 2'd1
`define FQL_HR_DATA 2'd2
// host command register fields
`define FQL_CMD_NRD_LSB 8
`define FQL_CMD_NRD_MSB 9
`endif

/* File: logic/fql_pkg.sv */
package fql_pkg;
  // what the program/erase engine is running
  typedef enum logic [1:0] {
    FQL_ENG_IDLE = 2'b00,
    FQL_ENG_PROG = 2'b01,
    FQL_ENG_ERASE = 2'b10,
    FQL_ENG_CHIP = 2'b11
  } fql_eng_e;
  // device power state, gray along awake-entering-asleep-waking
  typedef enum logic [1:0] {
    FQL_PWR_AWAKE = 2'b00,
    FQL_PWR_ENTER = 2'b01,
    FQL_PWR_SLEEP = 2'b11,
    FQL_PWR_WAKE = 2'b10
  } fql_pwr_e;
  // host sequencer state
  typedef enum logic [2:0] {
    FQL_HS_IDLE = 3'b000,
    FQL_HS_LEAD = 3'b001,
    FQL_HS_LOW = 3'b011,
    FQL_HS_HIGH = 3'b010,
    FQL_HS_TAIL = 3'b110,
    FQL_HS_GAP = 3'b111
  } fql_hst_e;
endpackage

/* File: logic/fql_link_if.sv */
`timescale 1ns/10ps
// serial link between host controller and flash command interpreter
interface fql_link_if;
  logic cs_n; // chip select, low frames a command
  logic sck; // serial clock made by the host
  logic [3:0] h_io; // host data out
  logic [3:0] h_oe; // host drive enables
  logic [3:0] d_io; // device data out
  logic [3:0] d_oe; // device drive enables
  logic [3:0] io; // resolved line level, pulled high when idle
  // resolve each data line from the enables
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      if (h_oe[i]) begin
        io[i] = h_io[i];
      end else if (d_oe[i]) begin
        io[i] = d_io[i];
      end else begin
        io[i] = 1'b1;
      end
    end
  end
  modport host (output cs_n, output sck, output h_io, output h_oe,
    input io);
  modport dev (input cs_n, input sck, input io, output d_io,
    output d_oe);
endinterface

/* File: logic/fql_dev.sv */
`timescale 1ns/10ps
`include "fql_regs.svh"
// What this block does
// - quad entry makes later commands four-line
// - quad exit only as two-nibble cycle
// - host frames quad exit with select
// - both pause and continue opcodes recognised
// - paused flags in function bits two, three
// - pause ignored during whole-array erase
// - erase pause blocks status write, erases
// - program pause blocks status write, programs
// - erase pause sets flag, busy until ready
// - program pause sets flag, busy until ready
// - any pause clears the write latch
// - host waits ready time after pause
// - continue restarts engine, clears paused flag
// - host waits before pausing again
// - quad cycle is two nibbles, high first
// - reads and id accepted while paused
// - writes and locks only under erase pause
// - reset needs arm command right before
// - sleep only on select rise after opcode
// - asleep, only wake command is recognised
// - host holds select high while waking
// - busy flag follows running engine
module fql_dev #(
  parameter int SETTLE_CYC = `FQL_SUS_CYC
) (
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  fql_link_if.dev link,
  input wire logic i_engine_busy,
  input fql_pkg::fql_eng_e i_engine_op,
  output logic o_cmd_valid,
  output logic [7:0] o_cmd_code,
  output logic o_pause_req,
  output logic o_continue_req,
  output logic o_soft_reset,
  output logic o_quad_mode,
  output logic o_program_paused_flag,
  output logic o_erase_paused_flag,
  output logic o_write_latch_flag,
  output logic o_write_busy_flag,
  output logic o_deep_sleep
);
  // whole state of the interpreter
  typedef struct packed {
    logic sel_a; // select sync, first stage
    logic sel_b; // select sync, second stage
    logic sel_p; // previous synced select
    logic ck_a; // clock sync, first stage
    logic ck_b; // clock sync, second stage
    logic ck_p; // previous synced clock
    logic [3:0] io_a; // data sync, first stage
    logic [3:0] io_b; // data sync, second stage
    logic [3:0] nbits; // bits taken in this frame, 9 means more
    logic [7:0] op; // opcode shift register
    logic quad; // four-line protocol active
    logic ppause; // program paused
    logic epause; // erase paused
    logic wlatch; // write enable latch
    logic rst_arm; // previous command armed reset
    logic settle; // pause in progress, not yet ready
    fql_pkg::fql_pwr_e pwr; // power state
    logic [15:0] cnt; // pause settle counter
    logic [15:0] pcnt; // power transition counter
    logic [7:0] tx; // read-back byte, rotated out
    logic tx_on; // read-back active in this frame
    logic [3:0] dout; // line data
    logic [3:0] doe; // line enables
    logic cmd_v; // forwarded command pulse
    logic [7:0] cmd_c; // forwarded opcode
    logic pause_p; // pause engine pulse
    logic cont_p; // continue engine pulse
    logic rst_p; // soft reset pulse
  } dev_s;

  dev_s st_q;
  dev_s st_d;
  logic ck_rise; // synced clock rising inside frame
  logic ck_fall; // synced clock falling inside frame
  logic frame_end; // synced select released
  logic op_done; // opcode just completed
  logic any_pause; // either pause flag set
  logic write_busy_flag; // write in progress
  logic [3:0] step; // bits per clock
  logic [3:0] nb_next; // bits after this clock
  logic ok; // command allowed in present state

  // opcodes accepted under either pause
  function automatic logic susp_both(input logic [7:0] c);
    case (c)
      8'h03, 8'h0b, 8'hbb, 8'h3b, 8'heb, 8'h6b, 8'h0d, 8'hbd,
      8'hed, 8'h05, 8'h48, 8'h82, 8'h7a, 8'h30, 8'hab, 8'hc0,
      8'h63, 8'h83, 8'h61, 8'h81, 8'h9f, 8'h90, 8'haf, 8'h4b,
      8'h5a, 8'h00, 8'h66, 8'h99, 8'h68, 8'h14: susp_both = 1'b1;
      default: susp_both = 1'b0;
    endcase
  endfunction

  // opcodes accepted only under erase pause
  function automatic logic susp_erase(input logic [7:0] c);
    case (c)
      `FQL_OP_PP, `FQL_OP_PPQ_A, `FQL_OP_PPQ_B, `FQL_OP_WRITE_LATCH_SET_CMD,
      `FQL_OP_LOCK, `FQL_OP_UNLOCK, `FQL_OP_PAUSE_A,
      `FQL_OP_PAUSE_B: susp_erase = 1'b1;
      default: susp_erase = 1'b0;
    endcase
  endfunction

  // opcodes the interpreter executes itself
  function automatic logic is_local(input logic [7:0] c);
    case (c)
      `FQL_OP_QUAD_ENTER, `FQL_OP_QUAD_EXIT, `FQL_OP_PAUSE_A,
      `FQL_OP_PAUSE_B, `FQL_OP_CONT_A, `FQL_OP_CONT_B,
      `FQL_OP_SLEEP, `FQL_OP_WAKE, `FQL_OP_WRITE_LATCH_SET_CMD, `FQL_OP_WRDI,
      `FQL_OP_RST_ARM, `FQL_OP_RST: is_local = 1'b1;
      default: is_local = 1'b0;
    endcase
  endfunction

  // same gate as ok except for the wake opcode, for the opcode arriving this cycle
  function automatic logic ok_next(input logic [7:0] c);
    if (st_q.pwr != fql_pkg::FQL_PWR_AWAKE) begin
      ok_next = 1'b0;
    end else if (st_q.settle) begin
      ok_next = (c == `FQL_OP_STAT_RD);
    end else if (st_q.ppause) begin
      ok_next = susp_both(c);
    end else if (st_q.epause) begin
      ok_next = susp_both(c) || susp_erase(c);
    end else begin
      ok_next = 1'b1;
    end
  endfunction

  // decode edges and gate the opcode against the present state
  always_comb begin
    ck_rise = st_q.sel_b && st_q.ck_b && !st_q.ck_p;
    ck_fall = st_q.sel_b && !st_q.ck_b && st_q.ck_p;
    frame_end = !st_q.sel_b && st_q.sel_p;
    step = st_q.quad ? `FQL_NIB_BITS : 4'd1;
    nb_next = st_q.nbits + step;
    op_done = ck_rise && (nb_next == `FQL_OP_BITS);
    any_pause = st_q.ppause || st_q.epause;
    write_busy_flag = st_q.settle || (i_engine_busy && !any_pause);
    if (st_q.pwr == fql_pkg::FQL_PWR_SLEEP) begin
      ok = (st_q.op == `FQL_OP_WAKE) && !i_engine_busy;
    end else if (st_q.pwr != fql_pkg::FQL_PWR_AWAKE) begin
      ok = 1'b0;
    end else if (st_q.settle) begin
      ok = (st_q.op == `FQL_OP_STAT_RD);
    end else if (st_q.ppause) begin
      ok = susp_both(st_q.op);
    end else if (st_q.epause) begin
      ok = susp_both(st_q.op) || susp_erase(st_q.op);
    end else begin
      ok = (st_q.op != `FQL_OP_WAKE);
    end
  end

  // next state of the interpreter
  always_comb begin
    st_d = st_q;
    st_d.cmd_v = 1'b0;
    st_d.pause_p = 1'b0;
    st_d.cont_p = 1'b0;
    st_d.rst_p = 1'b0;
    // two flip-flops on every pin
    st_d.sel_a = !link.cs_n;
    st_d.sel_b = st_q.sel_a;
    st_d.sel_p = st_q.sel_b;
    st_d.ck_a = link.sck;
    st_d.ck_b = st_q.ck_a;
    st_d.ck_p = st_q.ck_b;
    st_d.io_a = link.io;
    st_d.io_b = st_q.io_a;
    // timers
    if (st_q.cnt != 16'h0000) begin
      st_d.cnt = st_q.cnt - 16'h0001;
    end else begin
      st_d.settle = 1'b0; // ready again after pause
    end
    if (st_q.pcnt != 16'h0000) begin
      st_d.pcnt = st_q.pcnt - 16'h0001;
    end else if (st_q.pwr == fql_pkg::FQL_PWR_ENTER) begin
      st_d.pwr = fql_pkg::FQL_PWR_SLEEP;
    end else if (st_q.pwr == fql_pkg::FQL_PWR_WAKE) begin
      st_d.pwr = fql_pkg::FQL_PWR_AWAKE;
    end
    // shift opcode in, high nibble or high bit first
    if (ck_rise) begin
      if (st_q.nbits < `FQL_OP_BITS) begin
        st_d.nbits = nb_next;
        if (st_q.quad) begin
          st_d.op = {st_q.op[3:0], st_q.io_b};
        end else begin
          st_d.op = {st_q.op[6:0], st_q.io_b[0]};
        end
      end else begin
        st_d.nbits = 4'd9; // clocks past the opcode
      end
    end
    // opcode complete: forward engine commands, load read-back
    if (op_done) begin
      st_d.tx_on = 1'b0;
      if (!is_local(st_d.op) && ok_next(st_d.op)) begin
        st_d.cmd_v = 1'b1;
        st_d.cmd_c = st_d.op;
        if (st_d.op == `FQL_OP_STAT_RD) begin
          st_d.tx = 8'h00;
          st_d.tx[`FQL_SR_BUSY] = write_busy_flag;
          st_d.tx[`FQL_SR_WLATCH] = st_q.wlatch;
          st_d.tx_on = 1'b1;
        end else if (st_d.op == `FQL_OP_FUNC_RD) begin
          st_d.tx = 8'h00;
          st_d.tx[`FQL_FR_PPAUSE] = st_q.ppause;
          st_d.tx[`FQL_FR_EPAUSE] = st_q.epause;
          st_d.tx_on = 1'b1;
        end
      end
    end
    // drive read-back after each falling clock, repeating the byte
    if (ck_fall && st_q.tx_on) begin
      if (st_q.quad) begin
        st_d.dout = st_q.tx[7:4];
        st_d.doe = 4'hf;
        st_d.tx = {st_q.tx[3:0], st_q.tx[7:4]};
      end else begin
        st_d.dout = {2'b00, st_q.tx[7], 1'b0};
        st_d.doe = 4'h2;
        st_d.tx = {st_q.tx[6:0], st_q.tx[7]};
      end
    end
    // frame end: local commands act only on an exact opcode
    if (frame_end) begin
      st_d.nbits = 4'd0;
      st_d.tx_on = 1'b0;
      st_d.doe = 4'h0;
      if (st_q.nbits >= `FQL_OP_BITS) begin
        st_d.rst_arm = 1'b0;
      end
      if (st_q.nbits == `FQL_OP_BITS && ok) begin
        unique case (st_q.op)
          `FQL_OP_QUAD_ENTER: begin
            st_d.quad = 1'b1;
          end
          `FQL_OP_QUAD_EXIT: begin
            if (st_q.quad) begin
              st_d.quad = 1'b0;
            end
          end
          `FQL_OP_PAUSE_A, `FQL_OP_PAUSE_B: begin
            if (i_engine_busy && !st_q.ppause) begin
              if (i_engine_op == fql_pkg::FQL_ENG_PROG) begin
                st_d.ppause = 1'b1;
                st_d.wlatch = 1'b0;
                st_d.settle = 1'b1;
                st_d.cnt = 16'(SETTLE_CYC);
                st_d.pause_p = 1'b1;
              end else if (i_engine_op == fql_pkg::FQL_ENG_ERASE &&
                           !st_q.epause) begin
                st_d.epause = 1'b1;
                st_d.wlatch = 1'b0;
                st_d.settle = 1'b1;
                st_d.cnt = 16'(SETTLE_CYC);
                st_d.pause_p = 1'b1;
              end
              // a whole-array erase keeps running untouched
            end
          end
          `FQL_OP_CONT_A, `FQL_OP_CONT_B: begin
            if (st_q.ppause) begin
              st_d.ppause = 1'b0;
              st_d.cont_p = 1'b1;
            end else if (st_q.epause) begin
              st_d.epause = 1'b0;
              st_d.cont_p = 1'b1;
            end
          end
          `FQL_OP_SLEEP: begin
            st_d.pwr = fql_pkg::FQL_PWR_ENTER;
            st_d.pcnt = 16'(`FQL_DP_CYC);
          end
          `FQL_OP_WAKE: begin
            st_d.pwr = fql_pkg::FQL_PWR_WAKE;
            st_d.pcnt = 16'(`FQL_RES_CYC);
          end
          `FQL_OP_WRITE_LATCH_SET_CMD: begin
            st_d.wlatch = 1'b1;
          end
          `FQL_OP_WRDI: begin
            st_d.wlatch = 1'b0;
          end
          `FQL_OP_RST_ARM: begin
            st_d.rst_arm = 1'b1;
          end
          `FQL_OP_RST: begin
            if (st_q.rst_arm) begin
              st_d.rst_p = 1'b1;
              st_d.quad = 1'b0;
              st_d.wlatch = 1'b0;
            end
          end
          default: begin
          end
        endcase
      end
    end
  end

  // register the state
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // outputs
  assign link.d_io = st_q.dout;
  assign link.d_oe = st_q.doe;
  assign o_cmd_valid = st_q.cmd_v;
  assign o_cmd_code = st_q.cmd_c;
  assign o_pause_req = st_q.pause_p;
  assign o_continue_req = st_q.cont_p;
  assign o_soft_reset = st_q.rst_p;
  assign o_quad_mode = st_q.quad;
  assign o_program_paused_flag = st_q.ppause;
  assign o_erase_paused_flag = st_q.epause;
  assign o_write_latch_flag = st_q.wlatch;
  assign o_write_busy_flag = write_busy_flag;
  assign o_deep_sleep = (st_q.pwr == fql_pkg::FQL_PWR_SLEEP);
endmodule

/* File: logic/fql_host.sv */
`timescale 1ns/10ps
`include "fql_regs.svh"
// host controller: avalon slave in, serial frames out
module fql_host #(
  parameter int SUS_CYC = `FQL_SUS_CYC,
  parameter int RS_CYC = `FQL_RS_CYC,
  parameter int HALF = `FQL_SCK_HALF
) (
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  input wire logic [1:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  fql_link_if.host link
);
  // whole state of the host
  typedef struct packed {
    fql_pkg::fql_hst_e st; // sequencer state
    logic sel; // select active
    logic sck; // serial clock
    logic [3:0] hio; // line data
    logic [3:0] hoe; // line enables
    logic [7:0] op; // opcode of this frame
    logic [7:0] sh; // opcode shift register
    logic [3:0] oc; // opcode units left
    logic [4:0] rc; // read units left
    logic rdph; // present clock is a read unit
    logic [15:0] div; // half period and gap counter
    logic [15:0] rs; // continue-to-pause guard
    logic [23:0] rx; // read data
    logic quad; // four-line protocol in use
    logic [3:0] io_a; // data sync, first stage
    logic [3:0] io_b; // data sync, second stage
    logic rack; // read answered
    logic [31:0] rdata; // read data to bus
  } hst_s;

  hst_s st_q;
  hst_s st_d;
  logic is_pause; // written opcode is a pause
  logic start_ok; // command register write may be taken
  logic [1:0] nrd; // bytes to read back

  // decide whether a command write may start now
  always_comb begin
    is_pause = (i_avs_writedata[7:0] == `FQL_OP_PAUSE_A) ||
               (i_avs_writedata[7:0] == `FQL_OP_PAUSE_B);
    nrd = i_avs_writedata[`FQL_CMD_NRD_MSB:`FQL_CMD_NRD_LSB];
    start_ok = (st_q.st == fql_pkg::FQL_HS_IDLE) &&
               !(is_pause && st_q.rs != 16'h0000);
  end

  // sequencer and bus slave
  always_comb begin
    st_d = st_q;
    st_d.io_a = link.io;
    st_d.io_b = st_q.io_a;
    st_d.rack = i_avs_read && !st_q.rack;
    if (st_q.rs != 16'h0000) begin
      st_d.rs = st_q.rs - 16'h0001;
    end
    // register reads, answered one cycle later
    if (i_avs_read && !st_q.rack) begin
      unique case (i_avs_address)
        `FQL_HR_STAT: st_d.rdata = {30'h0, st_q.quad,
                        st_q.st != fql_pkg::FQL_HS_IDLE};
        `FQL_HR_DATA: st_d.rdata = {8'h00, st_q.rx};
        default: st_d.rdata = 32'h0000_0000;
      endcase
    end
    if (st_q.div != 16'h0000) begin
      st_d.div = st_q.div - 16'h0001;
    end
    unique case (st_q.st)
      fql_pkg::FQL_HS_IDLE: begin
        if (i_avs_write && i_avs_address == `FQL_HR_CMD && start_ok) begin
          st_d.op = i_avs_writedata[7:0];
          st_d.sh = i_avs_writedata[7:0];
          st_d.oc = st_q.quad ? 4'd2 : 4'd8;
          st_d.rc = st_q.quad ? 5'({nrd, 1'b0}) : 5'({nrd, 3'b000});
          st_d.rx = 24'h000000;
          st_d.sel = 1'b1;
          st_d.div = 16'(HALF);
          st_d.st = fql_pkg::FQL_HS_LEAD;
        end
      end
      fql_pkg::FQL_HS_LEAD, fql_pkg::FQL_HS_HIGH: begin
        if (st_q.div == 16'h0000) begin
          if (st_q.st == fql_pkg::FQL_HS_HIGH) begin
            st_d.sck = 1'b0;
            if (st_q.rdph) begin
              st_d.rx = st_q.quad ? {st_q.rx[19:0], st_q.io_b} :
                                    {st_q.rx[22:0], st_q.io_b[1]};
            end
          end
          st_d.div = 16'(HALF);
          if (st_q.oc == 4'd0 && st_q.rc == 5'd0) begin
            st_d.hoe = 4'h0;
            st_d.st = fql_pkg::FQL_HS_TAIL;
          end else begin
            st_d.st = fql_pkg::FQL_HS_LOW;
            if (st_q.oc != 4'd0) begin
              if (st_q.quad) begin
                st_d.hio = st_q.sh[7:4];
                st_d.hoe = 4'hf;
                st_d.sh = {st_q.sh[3:0], 4'h0};
              end else begin
                st_d.hio = {3'b000, st_q.sh[7]};
                st_d.hoe = 4'h1;
                st_d.sh = {st_q.sh[6:0], 1'b0};
              end
            end else begin
              st_d.hoe = 4'h0;
            end
          end
        end
      end
      fql_pkg::FQL_HS_LOW: begin
        if (st_q.div == 16'h0000) begin
          st_d.sck = 1'b1;
          st_d.div = 16'(HALF);
          st_d.rdph = (st_q.oc == 4'd0);
          if (st_q.oc != 4'd0) begin
            st_d.oc = st_q.oc - 4'd1;
          end else begin
            st_d.rc = st_q.rc - 5'd1;
          end
          st_d.st = fql_pkg::FQL_HS_HIGH;
        end
      end
      fql_pkg::FQL_HS_TAIL: begin
        if (st_q.div == 16'h0000) begin
          st_d.sel = 1'b0;
          st_d.st = fql_pkg::FQL_HS_GAP;
          st_d.div = 16'(HALF);
          if (st_q.op == `FQL_OP_QUAD_ENTER) begin
            st_d.quad = 1'b1;
          end else if (st_q.op == `FQL_OP_QUAD_EXIT) begin
            st_d.quad = 1'b0;
          end
          if (st_q.op == `FQL_OP_PAUSE_A ||
              st_q.op == `FQL_OP_PAUSE_B) begin
            st_d.div = 16'(SUS_CYC);
          end else if (st_q.op == `FQL_OP_WAKE) begin
            st_d.div = 16'(`FQL_RES_CYC);
          end else if (st_q.op == `FQL_OP_CONT_A ||
                       st_q.op == `FQL_OP_CONT_B) begin
            st_d.rs = 16'(RS_CYC);
          end
        end
      end
      fql_pkg::FQL_HS_GAP: begin
        if (st_q.div == 16'h0000) begin
          st_d.st = fql_pkg::FQL_HS_IDLE;
        end
      end
      default: begin
        st_d.st = fql_pkg::FQL_HS_IDLE;
      end
    endcase
  end

  // register the state
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // outputs
  assign o_avs_readdata = st_q.rdata;
  assign o_avs_waitrequest = (i_avs_read && !st_q.rack) ||
    (i_avs_write && i_avs_address == `FQL_HR_CMD && !start_ok);
  assign link.cs_n = !st_q.sel;
  assign link.sck = st_q.sck;
  assign link.h_io = st_q.hio;
  assign link.h_oe = st_q.hoe;
endmodule

/* File: verification/fql_link_properties.sv */
`timescale 1ns/10ps
// watches the serial link between the two ends
module fql_link_properties (
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic [3:0] h_io,
  input wire logic [3:0] h_oe,
  input wire logic [3:0] d_io,
  input wire logic [3:0] d_oe,
  input wire logic [3:0] io
);
  // one clock domain, checks muted in reset except a_reset_quiet
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (i_sys_rst);
  a_sck_idle_low: assert property (cs_n |-> !sck)
    else $error("link clock moves outside a frame");
  a_no_drive_clash: assert property ((h_oe & d_oe) == 4'h0)
    else $error("both ends drive one data line");
  a_reset_quiet: assert property (disable iff (1'b0)
    i_sys_rst |=> cs_n && !sck && h_oe == 4'h0 && d_oe == 4'h0)
    else $error("link not quiet after reset");
  a_dev_idle_off: assert property (cs_n [*6] |-> d_oe == 4'h0)
    else $error("device drives while deselected");
  a_data_hold: assert property (sck && $past(sck) |-> $stable(h_io))
    else $error("host data moves while clock high");
  a_high_phase: assert property ($rose(sck) |-> sck [*4])
    else $error("link clock high phase too short");
  a_select_lead: assert property ($fell(cs_n) |-> !sck [*4])
    else $error("clock rises too soon after select");
  a_select_gap: assert property ($rose(cs_n) |-> cs_n [*4])
    else $error("select high gap too short");
  // main traffic kinds seen
  c_frame: cover property ($fell(cs_n));
  c_dev_reply: cover property (d_oe != 4'h0);
  c_quad: cover property (h_oe == 4'hf);
endmodule

/* File: verification/test_flash_qpi_suspend_powerdown_ctl.sv */
`timescale 1ns/10ps
// host and device joined; bus calls with expected flag values
module test_flash_qpi_suspend_powerdown_ctl;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [1:0] adr = 2'h0;
  logic rd = 1'b0, wr = 1'b0, eb = 1'b0;
  logic [31:0] wd = 32'h0, rdat, q;
  fql_pkg::fql_eng_e eo = fql_pkg::FQL_ENG_IDLE; // engine kind
  logic wq, qm, pf, ef, wl, wb, ds, sr;
  logic cv, pp, cp; // forward, pause and continue pulses
  logic [7:0] cc; // last forwarded opcode
  logic [7:0] fl; // flags packed for compares
  int mismatches = 0, cmp_count = 0, nsr = 0, npz = 0, ncn = 0, nfw = 0;
  // pause, continue, flags after pause, function byte, after latch set
  localparam logic [7:0] TB [2][5] = '{'{8'h75, 8'h7a, 8'h04, 8'h08,
    8'h06}, '{8'hb0, 8'h30, 8'h08, 8'h04, 8'h08}};
  assign fl = {2'h0, qm, ds, pf, ef, wl, wb};
  always #2.5 clk = ~clk;
  // count soft reset, pause, continue and forward pulses
  always @(posedge clk) begin
    if (sr === 1'b1) nsr <= nsr + 1;
    if (pp === 1'b1) npz <= npz + 1;
    if (cp === 1'b1) ncn <= ncn + 1;
    if (cv === 1'b1) nfw <= nfw + 1;
  end
  fql_link_if lk ();
  fql_host #(.SUS_CYC(50), .RS_CYC(40), .HALF(8)) i_fql_host (
    .i_clk_sys(clk), .i_sys_rst(rst), .i_avs_address(adr),
    .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd),
    .o_avs_readdata(rdat), .o_avs_waitrequest(wq), .link(lk));
  fql_dev #(.SETTLE_CYC(50)) i_fql_dev (.i_clk_sys(clk),
    .i_sys_rst(rst), .link(lk), .i_engine_busy(eb), .i_engine_op(eo),
    .o_cmd_valid(cv), .o_cmd_code(cc), .o_pause_req(pp), .o_continue_req(cp),
    .o_soft_reset(sr), .o_quad_mode(qm), .o_program_paused_flag(pf),
    .o_erase_paused_flag(ef), .o_write_latch_flag(wl),
    .o_write_busy_flag(wb), .o_deep_sleep(ds));
  fql_link_properties i_fql_link_properties (.i_clk_sys(clk),
    .i_sys_rst(rst), .cs_n(lk.cs_n), .sck(lk.sck), .h_io(lk.h_io),
    .h_oe(lk.h_oe), .d_io(lk.d_io), .d_oe(lk.d_oe), .io(lk.io));
  // compare and count
  task automatic chk(input logic [7:0] g, e);
    cmp_count++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // one avalon cycle, held until waitrequest is sampled low at an edge
  task automatic bus(input logic [1:0] a, input logic w,
    input logic [31:0] d);
    @(posedge clk);
    adr <= a;
    wd <= d;
    wr <= w;
    rd <= !w;
    @(posedge clk);
    while (wq !== 1'b0) begin
      @(posedge clk);
    end
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  // send one opcode, poll host busy until clear; the watchdog ends a hang
  task automatic cmd(input logic [7:0] op, input logic [1:0] nb);
    bus(2'h0, 1'b1, {22'h0, nb, op});
    do begin
      bus(2'h1, 1'b0, 32'h0);
    end while (q[0] !== 1'b0);
  endtask
  // read one byte back through the data register
  task automatic rdb(input logic [7:0] op, e);
    cmd(op, 2'h1);
    bus(2'h2, 1'b0, 32'h0);
    chk(q[7:0], e);
  endtask
  task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // hang guard
  initial begin
    #200000;
    mismatches++;
    tally_and_finish();
  end
  // main sequence
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    chk(fl, 8'h00);
    bus(2'h3, 1'b0, 32'h0);
    chk(q[7:0], 8'h00);
    eb <= 1'b1;
    eo <= fql_pkg::FQL_ENG_ERASE;
    cmd(8'h06, 2'h0);
    rdb(8'h05, 8'h03);
    for (int i = 0; i < 2; i++) begin
      eo <= i ? fql_pkg::FQL_ENG_PROG : fql_pkg::FQL_ENG_ERASE;
      cmd(TB[i][0], 2'h0);
      repeat (10) @(posedge clk);
      chk(fl, TB[i][2]);
      chk(npz[7:0], 8'(i + 1));
      rdb(8'h48, TB[i][3]);
      chk(cc, 8'h48);
      cmd(8'h06, 2'h0);
      chk(fl, TB[i][4]);
      cmd(TB[i][1], 2'h0);
      chk(fl & 8'h0d, 8'h01);
      chk(ncn[7:0], 8'(i + 1));
    end
    eo <= fql_pkg::FQL_ENG_CHIP;
    cmd(8'h75, 2'h0);
    chk(fl & 8'h0d, 8'h01);
    chk(npz[7:0], 8'h02);
    cmd(8'h99, 2'h0);
    chk(nsr[7:0], 8'h00);
    cmd(8'h66, 2'h0);
    cmd(8'h99, 2'h0);
    chk(nsr[7:0], 8'h01);
    cmd(8'h35, 2'h0);
    chk(q[7:0], 8'h02);
    rdb(8'h05, 8'h01);
    chk(nfw[7:0], 8'h04);
    cmd(8'hf5, 2'h0);
    chk(fl & 8'h20, 8'h00);
    eb <= 1'b0;
    cmd(8'hb9, 2'h0);
    repeat (700) @(posedge clk);
    chk(fl, 8'h10);
    cmd(8'h06, 2'h0);
    chk(fl, 8'h10);
    cmd(8'hab, 2'h0);
    repeat (10) @(posedge clk);
    cmd(8'h06, 2'h0);
    chk(fl, 8'h02);
    tally_and_finish();
  end
endmodule
